/* src/ltws_sram.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ltws_params.svh"

module ltws_sram #(
    parameter int ADDR_W = `LTWS_ADDR_W,
    parameter int DATA_W = `LTWS_DATA_W,
    parameter bit FLOW_THROUGH = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clock_hold_n_i,
    input wire logic chip_select_a_n_i,
    input wire logic chip_select_b_i,
    input wire logic chip_select_c_n_i,
    input wire logic burst_advance_load_i,
    input wire logic read_write_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [`LTWS_LANES-1:0] byte_lane_write_n_i,
    input wire logic output_enable_n_i,
    input wire logic burst_order_select_n_i,
    input wire logic sleep_request_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o
);

    localparam int LANE_W = DATA_W / `LTWS_LANES;

    logic en;
    logic chips_on;
    logic [DATA_W-1:0] mem [0:(1 << ADDR_W)-1];

    // Sleep request synchroniser
    logic sleep_meta_reg, sleep_sync2_reg, sleep_sync3_reg, asleep_reg;
    logic asleep_next;

    // Stage 1: command sampled on the last enabled edge
    ltws_pkg::ltws_op_e op_reg, op_next;
    logic [ADDR_W-1:0] base_reg, base_next;
    logic [`LTWS_BURST_W-1:0] cnt_reg, cnt_next;
    logic [`LTWS_LANES-1:0] lanes_reg, lanes_next;
    logic [ADDR_W-1:0] s1_addr;

    // Stage 2: command waiting for its write data
    ltws_pkg::ltws_op_e s2_op_reg, s2_op_next;
    logic [ADDR_W-1:0] s2_addr_reg, s2_addr_next;
    logic [`LTWS_LANES-1:0] s2_lanes_reg, s2_lanes_next;

    // Read output stage
    logic [DATA_W-1:0] dout_reg, dout_next;
    logic dout_en_reg, dout_en_next;

    logic wr_go;
    logic [ADDR_W-1:0] wr_addr;
    logic [`LTWS_LANES-1:0] wr_lanes;
    logic [DATA_W-1:0] mem_rd, wr_word;

    function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_w,
                                                      input logic [DATA_W-1:0] new_w,
                                                      input logic [`LTWS_LANES-1:0] lanes_n);
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < `LTWS_LANES; i++) begin
            if (!lanes_n[i]) begin
                res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction

    assign en = !clock_hold_n_i;
    assign chips_on = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;

    always_comb begin
        asleep_next = asleep_reg;
        if (sleep_sync2_reg == sleep_sync3_reg) begin
            asleep_next = sleep_sync3_reg;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sleep_meta_reg <= 1'b0;
            sleep_sync2_reg <= 1'b0;
            sleep_sync3_reg <= 1'b0;
            asleep_reg <= 1'b0;
        end else begin
            sleep_meta_reg <= sleep_request_i;
            sleep_sync2_reg <= sleep_meta_reg;
            sleep_sync3_reg <= sleep_sync2_reg;
            asleep_reg <= asleep_next;
        end
    end

    // Burst address: interleaved when the order select is high, linear when low
    assign s1_addr = {base_reg[ADDR_W-1:2],
                      burst_order_select_n_i ? (base_reg[1:0] ^ cnt_reg)
                                             : (base_reg[1:0] + cnt_reg)};

    always_comb begin
        op_next = op_reg;
        base_next = base_reg;
        cnt_next = cnt_reg;
        lanes_next = lanes_reg;
        if (en) begin
            lanes_next = byte_lane_write_n_i;
            if (asleep_reg) begin
                op_next = ltws_pkg::op_deselect;
            end else if (!burst_advance_load_i) begin
                base_next = addr_i;
                cnt_next = `LTWS_RST_CNT;
                if (!chips_on) begin
                    op_next = ltws_pkg::op_deselect;
                end else if (read_write_i) begin
                    op_next = ltws_pkg::op_read;
                end else begin
                    op_next = ltws_pkg::op_write;
                end
            end else begin
                cnt_next = cnt_reg + 2'h1;
            end
        end
    end

    // Write path: flow-through commits from stage 1, pipelined from stage 2
    assign wr_go = en && ((FLOW_THROUGH ? op_reg : s2_op_reg) == ltws_pkg::op_write);
    assign wr_addr = FLOW_THROUGH ? s1_addr : s2_addr_reg;
    assign wr_lanes = FLOW_THROUGH ? lanes_reg : s2_lanes_reg;
    assign wr_word = merge_lanes(mem[wr_addr], data_i, wr_lanes);
    assign mem_rd = mem[s1_addr];

    always_comb begin
        s2_op_next = s2_op_reg;
        s2_addr_next = s2_addr_reg;
        s2_lanes_next = s2_lanes_reg;
        dout_next = dout_reg;
        dout_en_next = dout_en_reg;
        if (en) begin
            s2_op_next = op_reg;
            s2_addr_next = s1_addr;
            s2_lanes_next = lanes_reg;
            dout_en_next = (op_reg == ltws_pkg::op_read);
            dout_next = mem_rd;
            // Forward a write committing on this edge to a read of the same word
            if (wr_go && (wr_addr == s1_addr)) begin
                dout_next = wr_word;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_reg <= ltws_pkg::op_deselect;
            base_reg <= '0;
            cnt_reg <= `LTWS_RST_CNT;
            lanes_reg <= `LTWS_RST_LANES;
            s2_op_reg <= ltws_pkg::op_deselect;
            s2_addr_reg <= '0;
            s2_lanes_reg <= `LTWS_RST_LANES;
            dout_reg <= '0;
            dout_en_reg <= 1'b0;
        end else begin
            op_reg <= op_next;
            base_reg <= base_next;
            cnt_reg <= cnt_next;
            lanes_reg <= lanes_next;
            s2_op_reg <= s2_op_next;
            s2_addr_reg <= s2_addr_next;
            s2_lanes_reg <= s2_lanes_next;
            dout_reg <= dout_next;
            dout_en_reg <= dout_en_next;
        end
    end

    // Array has no reset; contents survive sleep
    always_ff @(posedge clk_i) begin
        if (wr_go) begin
            mem[wr_addr] <= wr_word;
        end
    end

    assign data_o = FLOW_THROUGH ? mem_rd : dout_reg;
    assign data_oe_o = (FLOW_THROUGH ? (op_reg == ltws_pkg::op_read) : dout_en_reg)
                       && !output_enable_n_i && !sleep_request_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_load_write_capture: assert property (en && !asleep_reg && !burst_advance_load_i && chips_on && !read_write_i
        |=> op_reg == ltws_pkg::op_write && base_reg == $past(addr_i) && lanes_reg == $past(byte_lane_write_n_i))
        else $error("write command not registered");
    chk_deselect_load: assert property (en && !asleep_reg && !burst_advance_load_i && !chips_on
        |=> op_reg == ltws_pkg::op_deselect)
        else $error("inactive select did not deselect");
    chk_deselect_bus: assert property (en && op_reg == ltws_pkg::op_deselect
        |=> !dout_en_reg)
        else $error("deselect still drives the bus");
    chk_read_latency: assert property (en && op_reg == ltws_pkg::op_read
        |=> dout_en_reg && dout_reg == $past(wr_go && wr_addr == s1_addr ? wr_word : mem_rd))
        else $error("read data not presented on time");
    chk_no_write_drive: assert property (!FLOW_THROUGH && s2_op_reg == ltws_pkg::op_write
        |-> !data_oe_o)
        else $error("memory drives while write data is due");
    chk_async_oe_gate: assert property (output_enable_n_i || sleep_request_i |-> !data_oe_o)
        else $error("drivers on while disabled");
    chk_hold_freeze: assert property (!en
        |=> $stable(op_reg) && $stable(base_reg) && $stable(cnt_reg) && $stable(s2_op_reg) && $stable(dout_reg))
        else $error("state moved during clock hold");
    chk_burst_step: assert property (en && !asleep_reg && burst_advance_load_i
        |=> op_reg == $past(op_reg) && base_reg == $past(base_reg) && cnt_reg == $past(cnt_reg) + 2'h1)
        else $error("burst did not continue");
    chk_burst_order: assert property (s1_addr[1:0] == (burst_order_select_n_i ? base_reg[1:0] ^ cnt_reg
        : base_reg[1:0] + cnt_reg))
        else $error("burst address sequence wrong");
    chk_lane_travel: assert property (en |=> s2_lanes_reg == $past(lanes_reg) && s2_addr_reg == $past(s1_addr))
        else $error("write lanes lost their command");
    chk_sleep_ignore: assert property (en && asleep_reg |=> op_reg == ltws_pkg::op_deselect)
        else $error("input accepted while asleep");

    cov_read_burst: cover property (en && op_reg == ltws_pkg::op_read ##1 en && burst_advance_load_i
        ##1 en && burst_advance_load_i);
    cov_write_then_read: cover property (op_reg == ltws_pkg::op_write ##1 op_reg == ltws_pkg::op_read);
    cov_hold_in_read: cover property (op_reg == ltws_pkg::op_read && !en);
    cov_forward: cover property (en && wr_go && op_reg == ltws_pkg::op_read && wr_addr == s1_addr);

endmodule

`default_nettype wire

/* src/ltws_params.svh */
`ifndef LTWS_PARAMS_SVH
`define LTWS_PARAMS_SVH

`define LTWS_ADDR_W 20
`define LTWS_DATA_W 36
`define LTWS_LANES 4
`define LTWS_BURST_W 2
`define LTWS_LAT_PIPE 2
`define LTWS_LAT_FLOW 1
`define LTWS_RST_CNT 2'h0
`define LTWS_RST_LANES 4'hf

`endif

/* src/ltws_pkg.sv */
package ltws_pkg;

    // Command held in a pipeline stage; read and write differ in one bit
    typedef enum logic [1:0] {
        op_deselect = 2'b00,
        op_read = 2'b01,
        op_write = 2'b11
    } ltws_op_e;

endpackage

/* testbench/ltws_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module ltws_host_model #(
    parameter int DATA_W = 36
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hold_i,
    input wire logic wr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] data_o,
    output logic drive_o
);
    logic wr_d;
    logic [DATA_W-1:0] wdata_d;
    // Write data goes out one edge after the edge that samples its command; released pins toggle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_d <= 1'b0;
            drive_o <= 1'b0;
            wdata_d <= '0;
            data_o <= '0;
        end else if (!hold_i) begin
            wr_d <= wr_i;
            wdata_d <= wdata_i;
            drive_o <= wr_d;
            data_o <= wr_d ? wdata_d : ~data_o;
        end
    end
endmodule

`default_nettype wire

/* testbench/late_write_burst_sync_sram_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module late_write_burst_sync_sram_tb;
    localparam int DW = 36;
    logic clk_i = 0, rst_n_i = 0, hold = 0, csa_n = 1, csb = 1, csc_n = 0, burst_advance = 0, rw = 1;
    logic oe_n = 0, bos_n = 1, sleep = 0, host_wr = 0, host_drv, doe;
    logic [19:0] addr = '0, a1, a2, base;
    logic [3:0] lanes = '0, l1, l2;
    logic [DW-1:0] wdata = '0, din, dout, d1, d2, e2;
    logic [DW-1:0] mem [0:511];
    int err_count = 0, checks_done = 0, op1 = 0, op2 = 0, cur = 0, cnt = 0;

    initial forever #2 clk_i = ~clk_i;

    ltws_sram dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .clock_hold_n_i(hold), .chip_select_a_n_i(csa_n),
        .chip_select_b_i(csb), .chip_select_c_n_i(csc_n), .burst_advance_load_i(burst_advance), .read_write_i(rw),
        .addr_i(addr), .byte_lane_write_n_i(lanes), .output_enable_n_i(oe_n),
        .burst_order_select_n_i(bos_n), .sleep_request_i(sleep), .data_i(din), .data_o(dout),
        .data_oe_o(doe));
    ltws_host_model #(.DATA_W(DW)) host_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .hold_i(hold),
        .wr_i(host_wr), .wdata_i(wdata), .data_o(din), .drive_o(host_drv));

    task chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw, input logic [3:0] ln);
        for (int i = 0; i < 4; i++) begin
            if (!ln[i]) old[i*(DW/4) +: DW/4] = nw[i*(DW/4) +: DW/4];
        end
        return old;
    endfunction

    // Kind 1 read, 2 write, 3 advance; bad picks one inactive chip select; z marks a cycle taken while asleep
    task step(input int kind, input logic [19:0] a, input logic [3:0] ln, input logic [DW-1:0] wd,
              input int bad = 0, input logic h = 0, input logic z = 0);
        logic [19:0] ea;
        @(negedge clk_i);
        chk(doe, op2 == 1);
        if (op2 == 1) chk(dout, e2);
        chk(doe & host_drv, 0);
        hold = h;
        burst_advance = (kind == 3);
        rw = (kind != 2);
        addr = a;
        lanes = ln;
        wdata = wd;
        csa_n = (bad == 1);
        csb = (bad != 2);
        csc_n = (bad == 3);
        host_wr = !h && !z && ((kind == 2 && bad == 0) || (kind == 3 && cur == 2));
        ea = a;
        if (!h && kind == 3) begin
            cnt++;
            ea = {base[19:2], bos_n ? base[1:0] ^ cnt[1:0] : base[1:0] + cnt[1:0]};
        end else if (!h) begin
            cur = (bad != 0 || z) ? 0 : kind;
            base = a;
            cnt = 0;
        end
        @(posedge clk_i);
        if (!h) begin
            if (op2 == 2) mem[a2[8:0]] = merge(mem[a2[8:0]], d2, l2);
            if (op1 == 1) e2 = mem[a1[8:0]];
            op2 = op1; a2 = a1; l2 = l1; d2 = d1;
            op1 = cur; a1 = ea; l1 = ln; d1 = wd;
        end
    endtask

    task tally_and_finish;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge clk_i);
        chk(doe, 0);
        rst_n_i = 1;
        step(2, 20'h0_0010, 4'h0, 36'h1_2345_6789);
        step(1, 20'h0_0010, 4'hf, '0);
        step(2, 20'h0_0010, 4'b1010, 36'hf_ffff_ffff);
        step(2, 20'h0_0011, 4'h0, 36'h0_0a0a_0a0a);
        step(1, 20'h0_0010, 4'h0, '0);
        step(1, 20'h0_0011, 4'h0, '0);
        step(2, 20'h0_0012, 4'h0, 36'h5_5555_aaaa);
        for (int b = 1; b < 4; b++) step(1, 20'h0_0010, 4'h0, '0, b);
        step(1, 20'h0_0012, 4'h0, '0);
        for (int o = 0; o < 2; o++) begin
            step(1, 20'h0, 4'h0, '0, 1);
            step(1, 20'h0, 4'h0, '0, 1);
            @(negedge clk_i);
            bos_n = o[0];
            step(2, 20'h0_0104 + 20'(o), 4'h0, 36'h0_1000_0000 + 36'(o));
            for (int k = 1; k < 4; k++) step(3, 20'hf_ffff, 4'h0, 36'h0_2000_0000 + 36'(k), 1);
            step(1, 20'h0_0105 + 20'(o), 4'h0, '0);
            step(3, 20'h0_0000, 4'h0, '0, 2);
            step(3, 20'h0_0000, 4'h0, '0, 0, 1);
            step(3, 20'h0_0000, 4'h0, '0, 3);
            step(3, 20'h0_0000, 4'h0, '0);
        end
        step(1, 20'h0_0010, 4'h0, '0);
        step(1, 20'h0, 4'h0, '0, 1);
        step(1, 20'h0, 4'h0, '0, 1, 1);
        @(negedge clk_i);
        oe_n = 1;
        #0.5 chk(doe, 0);
        oe_n = 0;
        sleep = 1;
        #0.5 chk(doe, 0);
        sleep = 0;
        #0.5 chk(doe, 1);
        repeat (3) step(1, 20'h0, 4'h0, '0, 1);
        // Sleep: a write presented once the request is synchronised must be ignored
        @(negedge clk_i);
        sleep = 1;
        repeat (4) step(1, 20'h0, 4'h0, '0, 1);
        step(2, 20'h0_0010, 4'h0, 36'h0_dead_beef, 0, 0, 1);
        @(negedge clk_i);
        sleep = 0;
        repeat (4) step(1, 20'h0, 4'h0, '0, 1);
        step(1, 20'h0_0010, 4'h0, '0);
        repeat (3) step(1, 20'h0, 4'h0, '0, 1);
        tally_and_finish();
    end
endmodule

`default_nettype wire
